/* File: drc_pkg.sv */
package drc_pkg;
    // operating mode of the device, driven by the mode sequencer
    typedef enum logic [2:0] {
        MODE_NORMAL,
        MODE_STOP,
        MODE_RESTART,
        MODE_SLEEP,
        MODE_FAILSAFE
    } drc_mode_t;

    typedef enum logic [1:0] {
        SS_IDLE,
        SS_HOLD,
        SS_DONE
    } drc_ss_state_t;

    localparam int          ADDR_W            = 8;
    localparam int          DATA_W            = 32;

    localparam logic [7:0]  ADDR_HARDWARE_CONTROL_REGISTER      = 8'h00;
    localparam logic [7:0]  ADDR_CONV_STAT    = 8'h04;
    localparam logic [7:0]  ADDR_WAKE_STAT    = 8'h08;
    localparam logic [7:0]  ADDR_MODE_CTRL    = 8'h0C;
    localparam logic [7:0]  ADDR_STATE        = 8'h10;

    // hardware control register fields
    localparam int          HW_STEP_UP_EN     = 0;
    localparam int          HW_LEVEL_SEL      = 1;
    localparam int          HW_AUTO_EN        = 2;
    localparam int          HW_PIN_MOD_EN     = 3;
    localparam logic [3:0]  HARDWARE_CONTROL_REGISTER_RESET     = 4'h4;

    // converter status register fields
    localparam int          CS_SW_OPEN        = 0;
    localparam int          CS_SW_SHORT       = 1;
    localparam int          CS_OUT_BAND       = 2;
    localparam int          CS_STEP_UP_ACT    = 3;

    // wake status register field
    localparam int          WS_MOD_CHANGE     = 0;

    // soft-start timing
    localparam int          CLK_PERIOD_NS     = 8;
    localparam int          SW_PERIOD_NS      = 500;
    localparam int          SW_PERIOD_CYC     = SW_PERIOD_NS / CLK_PERIOD_NS;
    localparam logic [7:0]  SW_PERIOD_LAST    = 8'(SW_PERIOD_CYC - 1);
    localparam logic [3:0]  HOLD_PERIODS_LAST = 4'h7;
    localparam logic [7:0]  DUTY_MIN          = 8'h08;
    localparam logic [7:0]  DUTY_STEP         = 8'h08;
    localparam logic [7:0]  DUTY_MAX          = 8'hFF;
endpackage

/* File: drc_ss_if.sv */
`timescale 1ns/1ns
interface drc_ss_if;
    import drc_pkg::*;
    logic       start;
    logic       abort;
    logic       target_ok;
    logic [7:0] duty;
    logic       active;
    logic       done;

    modport ctrl (output start, output abort, output target_ok,
                  input duty, input active, input done);
    modport seq  (input start, input abort, input target_ok,
                  output duty, output active, output done);
endinterface

/* File: drc_soft_start.sv */
`timescale 1ns/1ns
module drc_soft_start (
    input  wire logic clk_sys,  // system clock
    input  wire logic resetn,   // async reset, active low
    drc_ss_if.seq     ss        // sequencer side
);
    import drc_pkg::*;

    drc_ss_state_t state;
    logic [7:0]    per_cnt;
    logic [3:0]    hold_cnt;
    wire           per_end  = (per_cnt == SW_PERIOD_LAST);
    wire           hold_end = per_end && (hold_cnt == HOLD_PERIODS_LAST);
    wire           at_max   = (ss.duty > DUTY_MAX - DUTY_STEP);

    assign ss.active = (state == SS_HOLD);
    assign ss.done   = (state == SS_DONE);

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            state    <= SS_IDLE;
            per_cnt  <= 8'h00;
            hold_cnt <= 4'h0;
            ss.duty  <= 8'h00;
        end else if (ss.abort) begin
            state    <= SS_IDLE;
            ss.duty  <= 8'h00;
        end else if (ss.start) begin
            state    <= SS_HOLD;                           // [RQ6]
            ss.duty  <= DUTY_MIN;                          // [RQ6]
            per_cnt  <= 8'h00;
            hold_cnt <= 4'h0;
        end else begin
            unique case (state)
                SS_IDLE: begin
                end
                SS_HOLD: begin
                    per_cnt <= per_end ? 8'h00 : per_cnt + 8'h01;
                    if (per_end) begin
                        hold_cnt <= hold_end ? 4'h0 : hold_cnt + 4'h1;   // [RQ7]
                    end
                    if (ss.target_ok) begin
                        state <= SS_DONE;                  // [RQ8]
                    end else if (hold_end) begin
                        ss.duty <= at_max ? DUTY_MAX : ss.duty + DUTY_STEP;  // [RQ7]
                    end
                end
                SS_DONE: begin
                end
            endcase
        end
    end

    a_ss_min_duty: assert property (@(posedge clk_sys) disable iff (!resetn)
        ss.start && !ss.abort |=> ss.active && ss.duty == DUTY_MIN)  // [RQ6]
        else $error("soft start did not open at minimum duty");

    a_ss_step_up: assert property (@(posedge clk_sys) disable iff (!resetn)
        ss.active && hold_end && !ss.target_ok && !ss.start && !ss.abort
        && !at_max |=> ss.duty == $past(ss.duty) + DUTY_STEP)  // [RQ7]
        else $error("soft start duty step wrong");

    a_ss_hold_keep: assert property (@(posedge clk_sys) disable iff (!resetn)
        ss.active && !hold_end && !ss.start && !ss.abort |=> $stable(ss.duty))  // [RQ7]
        else $error("soft start duty changed inside hold");
endmodule

/* File: drc_mode_control.sv */
// The plain strobed port and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
// Contract
// RQ1: converter runs in Normal, Stop, Restart only
// RQ2: buck uses PWM in Normal and Restart
// RQ3: entering Stop forces buck to PFM
// RQ4: PWM allows full duty on low supply
// RQ5: soft start at power-up and wake restart
// RQ6: soft start opens at minimum duty, holds
// RQ7: duty steps up after each hold phase
// RQ8: target reached hands over to closed loop
// RQ9: status reports switch pin faults, band
// RQ10: status bits change no mode or setting
// RQ11: host enables step-up; honoured Normal/Stop
// RQ12: level bit selects threshold and hysteresis
// RQ13: step-up on below threshold, off above hysteresis
// RQ14: active flag clears only above threshold
// RQ15: step-up always fixed-frequency PWM
// RQ16: Stop overload switches PWM, event, flag
// RQ17: host returns PFM by Stop command
// RQ18: auto transition suppressed when disabled
// RQ19: wake pin selects modulation when enabled
// RQ20: step-up held off unless enabled and active
module drc_mode_control (
    input  wire logic              clk_sys,         // system clock, 125 MHz
    input  wire logic              resetn,          // async reset, active low
    input  wire drc_pkg::drc_mode_t op_mode,        // current operating mode
    input  wire logic [7:0]        reg_addr,        // register byte address
    input  wire logic [31:0]       reg_wdata,       // register write data
    input  wire logic              reg_wr,          // write strobe
    input  wire logic              reg_rd,          // read strobe
    output      logic [31:0]       reg_rdata,       // read data, cycle after strobe
    input  wire logic              wake_input_pin,  // wake pin level
    input  wire logic              sw_open_cmp,     // buck switch pin open
    input  wire logic              sw_short_cmp,    // buck switch pin short
    input  wire logic              out_band_cmp,    // buck output outside band
    input  wire logic              load_over_cmp,   // buck load above transition
    input  wire logic              target_cmp,      // buck output reached target
    input  wire logic              low_supply_cmp,  // input supply low
    input  wire logic              below_th1_cmp,   // sense below threshold one
    input  wire logic              above_hys1_cmp,  // sense above th one plus hys one
    input  wire logic              below_th2_cmp,   // sense below threshold two
    input  wire logic              above_hys2_cmp,  // sense above th two plus hys two
    output      logic              buck_enable,     // buck stage running
    output      logic              buck_pwm,        // 1 PWM, 0 PFM
    output      logic              full_duty_allow, // 100% duty permitted
    output      logic [7:0]        ss_duty,         // soft-start duty code
    output      logic              ss_active,       // soft start in progress
    output      logic              closed_loop,     // closed-loop PWM regulation
    output      logic              step_up_on,      // step-up stage switching
    output      logic              step_up_pwm,     // step-up modulation, 1 PWM
    output      logic              step_up_level,   // 1 level one, 0 level two
    output      logic              mod_change_evt   // one-cycle interrupt event
);
    import drc_pkg::*;

    localparam int NSYNC = 10;

    drc_ss_if ss ();

    drc_soft_start u_ss (
        .clk_sys (clk_sys),
        .resetn  (resetn),
        .ss      (ss)
    );

    // two-stage synchronisers for all comparator and pin inputs
    logic [NSYNC-1:0] raw_in;
    logic [NSYNC-1:0] sync1;
    logic [NSYNC-1:0] sync2;
    assign raw_in = {above_hys2_cmp, below_th2_cmp, above_hys1_cmp, below_th1_cmp,
                     low_supply_cmp, target_cmp, load_over_cmp, out_band_cmp,
                     sw_short_cmp, wake_input_pin};

    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi++) begin : g_sync
            always_ff @(posedge clk_sys or negedge resetn) begin
                if (!resetn) begin
                    sync1[gi] <= 1'b0;
                    sync2[gi] <= 1'b0;
                end else begin
                    sync1[gi] <= raw_in[gi];
                    sync2[gi] <= sync1[gi];
                end
            end
        end
    endgenerate

    logic sw_open_s1;
    logic sw_open_s;
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            sw_open_s1 <= 1'b0;
            sw_open_s  <= 1'b0;
        end else begin
            sw_open_s1 <= sw_open_cmp;
            sw_open_s  <= sw_open_s1;
        end
    end

    wire wake_s      = sync2[0];
    wire sw_short_s  = sync2[1];
    wire out_band_s  = sync2[2];
    wire load_over_s = sync2[3];
    wire target_s    = sync2[4];
    wire low_sup_s   = sync2[5];
    wire below_th1_s = sync2[6];
    wire above_h1_s  = sync2[7];
    wire below_th2_s = sync2[8];
    wire above_h2_s  = sync2[9];

    function automatic logic mode_active(input drc_mode_t m);
        return (m == MODE_NORMAL) || (m == MODE_STOP) || (m == MODE_RESTART);
    endfunction

    function automatic logic mode_off(input drc_mode_t m);
        return (m == MODE_SLEEP) || (m == MODE_FAILSAFE);
    endfunction

    // registers
    logic [3:0] hardware_control_register;
    logic [3:0] conv_stat;
    logic       mod_flag;
    logic       pwm_latched;
    logic       powered;
    drc_mode_t  prev_mode;

    wire wr_hw    = reg_wr && (reg_addr == ADDR_HARDWARE_CONTROL_REGISTER);
    wire wr_cs    = reg_wr && (reg_addr == ADDR_CONV_STAT);
    wire wr_ws    = reg_wr && (reg_addr == ADDR_WAKE_STAT);
    wire stop_cmd = reg_wr && (reg_addr == ADDR_MODE_CTRL)
                    && (reg_wdata[2:0] == 3'(MODE_STOP));

    wire su_en_bit  = hardware_control_register[HW_STEP_UP_EN];
    wire level_sel  = hardware_control_register[HW_LEVEL_SEL];
    wire auto_en    = hardware_control_register[HW_AUTO_EN];
    wire pin_mod_en = hardware_control_register[HW_PIN_MOD_EN];

    wire in_stop    = (op_mode == MODE_STOP);
    wire stop_entry = in_stop && (prev_mode != MODE_STOP);
    wire active_now = mode_active(op_mode);

    // step-up threshold selection
    wire su_allowed = su_en_bit && (op_mode == MODE_NORMAL || in_stop);   // [RQ11] [RQ20]
    wire su_below   = level_sel ? below_th1_s : below_th2_s;              // [RQ12]
    wire su_above   = level_sel ? above_h1_s : above_h2_s;                // [RQ12]
    wire next_su_on = su_allowed && (su_below || (step_up_on && !su_above));  // [RQ13]
    wire su_rise    = next_su_on && !step_up_on;

    // buck modulation
    wire auto_trip  = in_stop && !stop_entry && !pin_mod_en && auto_en
                      && load_over_s && !pwm_latched;                     // [RQ16] [RQ18]
    wire next_latch = !in_stop || stop_entry || stop_cmd ? 1'b0
                      : (pwm_latched || auto_trip);                       // [RQ17]
    wire next_pwm   = !active_now ? 1'b0
                      : !in_stop ? 1'b1                                   // [RQ2]
                      : stop_entry ? 1'b0                                 // [RQ3]
                      : pin_mod_en ? wake_s                               // [RQ19]
                      : next_latch;                                       // [RQ16] [RQ17]

    wire ss_trigger = active_now && (!powered ||
                      (op_mode == MODE_RESTART && mode_off(prev_mode)));  // [RQ5]

    assign ss.start     = ss_trigger;
    assign ss.abort     = !active_now;
    assign ss.target_ok = target_s;
    assign ss_duty      = ss.duty;
    assign ss_active    = ss.active;
    assign closed_loop  = ss.done && buck_pwm;                            // [RQ8]
    assign step_up_pwm  = 1'b1;                                           // [RQ15]
    assign step_up_level = level_sel;

    wire cs_clear_ok = !su_below;                                         // [RQ14]
    wire [3:0] cs_set = {su_rise, out_band_s, sw_short_s, sw_open_s};     // [RQ9]
    wire [3:0] cs_w1c = wr_cs ? {reg_wdata[CS_STEP_UP_ACT] && cs_clear_ok,
                                 reg_wdata[CS_OUT_BAND], reg_wdata[CS_SW_SHORT],
                                 reg_wdata[CS_SW_OPEN]} : 4'h0;
    // set wins over clear; status writes touch nothing else
    wire [3:0] next_cs  = cs_set | (conv_stat & ~cs_w1c);                 // [RQ10]
    wire next_mflag = auto_trip || (mod_flag && !(wr_ws && reg_wdata[WS_MOD_CHANGE]));

    wire [31:0] rd_mux =
        (reg_addr == ADDR_HARDWARE_CONTROL_REGISTER)   ? {28'h0, hardware_control_register} :
        (reg_addr == ADDR_CONV_STAT) ? {28'h0, conv_stat} :
        (reg_addr == ADDR_WAKE_STAT) ? {31'h0, mod_flag} :
        (reg_addr == ADDR_MODE_CTRL) ? {29'h0, op_mode} :
        (reg_addr == ADDR_STATE)     ? {26'h0, closed_loop, ss_active, step_up_on,
                                        buck_pwm, buck_enable, pwm_latched} :
        32'h0;

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            hardware_control_register   <= HARDWARE_CONTROL_REGISTER_RESET;
            conv_stat <= 4'h0;
            mod_flag  <= 1'b0;
            reg_rdata <= 32'h0;
        end else begin
            if (wr_hw) begin
                hardware_control_register <= reg_wdata[3:0];
            end
            conv_stat <= next_cs;
            mod_flag  <= next_mflag;                                      // [RQ16]
            reg_rdata <= reg_rd ? rd_mux : 32'h0;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            prev_mode       <= MODE_SLEEP;
            powered         <= 1'b0;
            pwm_latched     <= 1'b0;
            buck_enable     <= 1'b0;
            buck_pwm        <= 1'b0;
            full_duty_allow <= 1'b0;
            step_up_on      <= 1'b0;
            mod_change_evt  <= 1'b0;
        end else begin
            prev_mode       <= op_mode;
            powered         <= powered || ss_trigger;
            pwm_latched     <= next_latch;
            buck_enable     <= active_now;                                // [RQ1]
            buck_pwm        <= next_pwm;
            full_duty_allow <= next_pwm && low_sup_s;                     // [RQ4]
            step_up_on      <= next_su_on;                                // [RQ13]
            mod_change_evt  <= auto_trip;                                 // [RQ16]
        end
    end

    a_buck_off_sleep: assert property (@(posedge clk_sys) disable iff (!resetn)  // [RQ1]
        mode_off(op_mode) |=> !buck_enable && !step_up_on && !buck_pwm)
        else $error("converter not off in sleep or fail-safe");

    a_pwm_normal: assert property (@(posedge clk_sys) disable iff (!resetn)  // [RQ2]
        (op_mode == MODE_NORMAL || op_mode == MODE_RESTART) |=> buck_pwm)
        else $error("buck not in PWM in normal or restart");

    a_pfm_stop_entry: assert property (@(posedge clk_sys) disable iff (!resetn)  // [RQ3]
        stop_entry |=> !buck_pwm ##1 (pin_mod_en || $past(auto_trip) || !buck_pwm))
        else $error("stop entry did not select PFM");

    a_full_duty: assert property (@(posedge clk_sys) disable iff (!resetn)  // [RQ4]
        full_duty_allow |-> buck_pwm)
        else $error("full duty allowed outside PWM");

    a_ss_restart: assert property (@(posedge clk_sys) disable iff (!resetn)  // [RQ5]
        op_mode == MODE_RESTART && mode_off(prev_mode) |=> ss_active && ss_duty == DUTY_MIN)
        else $error("soft start missing on wake restart");

    a_closed_loop: assert property (@(posedge clk_sys) disable iff (!resetn)  // [RQ8]
        ss_active && target_s && !ss_trigger && active_now |=> !ss_active)
        else $error("soft start did not end at target");

    a_stepup_gate: assert property (@(posedge clk_sys) disable iff (!resetn)  // [RQ20]
        !su_allowed |=> !step_up_on)
        else $error("step-up on while not allowed");

    a_flag_guard: assert property (@(posedge clk_sys) disable iff (!resetn)  // [RQ14]
        conv_stat[CS_STEP_UP_ACT] && su_below |=> conv_stat[CS_STEP_UP_ACT])
        else $error("step-up flag cleared below threshold");

    a_auto_event: assert property (@(posedge clk_sys) disable iff (!resetn)  // [RQ16]
        auto_trip |=> mod_change_evt && mod_flag && buck_pwm)
        else $error("auto transition missed event, flag or PWM");

    a_auto_gate: assert property (@(posedge clk_sys) disable iff (!resetn)  // [RQ18]
        in_stop && !auto_en && !pin_mod_en && !pwm_latched && !stop_entry |=> !mod_change_evt)
        else $error("auto transition while disabled");

    a_pin_select: assert property (@(posedge clk_sys) disable iff (!resetn)  // [RQ19]
        in_stop && !stop_entry && pin_mod_en |=> buck_pwm == $past(wake_s))
        else $error("wake pin did not select modulation");
endmodule

/* File: drc_far_side.sv */
`timescale 1ns/1ns
module drc_far_side #(
    parameter logic [7:0] TH1    = 8'h64,  // threshold one code
    parameter logic [7:0] HYS1   = 8'h14,  // hysteresis one code
    parameter logic [7:0] TH2    = 8'h3C,  // threshold two code
    parameter logic [7:0] HYS2   = 8'h0A,  // hysteresis two code
    parameter logic [7:0] TARGET = 8'h18   // duty at which the buck output is on target
) (
    input  wire logic [7:0] sense_lvl,      // sensed supply code from the bench
    input  wire logic [7:0] ss_duty,        // soft-start duty from the block
    output      logic       below_th1,      // sense below threshold one
    output      logic       above_hys1,     // sense above threshold one plus hysteresis
    output      logic       below_th2,      // sense below threshold two
    output      logic       above_hys2,     // sense above threshold two plus hysteresis
    output      logic       target_cmp      // buck output reached its target
);
    // comparators are plain level functions of the sensed supply
    assign below_th1  = sense_lvl < TH1;
    assign above_hys1 = sense_lvl > 8'(TH1 + HYS1);
    assign below_th2  = sense_lvl < TH2;
    assign above_hys2 = sense_lvl > 8'(TH2 + HYS2);
    // output voltage follows the duty, so target is met once duty is high enough
    assign target_cmp = ss_duty >= TARGET;
endmodule

/* File: dcdc_regulator_mode_control_bench.sv */
`timescale 1ns/1ns
module dcdc_regulator_mode_control_bench;
    import drc_pkg::*;
    logic        clk_sys = 1'b0;
    logic        resetn;
    drc_mode_t   op_mode;
    logic [7:0]  reg_addr, sense_lvl;
    logic [31:0] reg_wdata, reg_rdata;
    logic        reg_wr, reg_rd, wake_input_pin, sw_open_cmp, sw_short_cmp, out_band_cmp;
    logic        load_over_cmp, low_supply_cmp, target_cmp;
    logic        below_th1, above_hys1, below_th2, above_hys2;
    logic        buck_enable, buck_pwm, full_duty_allow, ss_active, closed_loop;
    logic        step_up_on, step_up_pwm, step_up_level, mod_change_evt;
    logic [7:0]  ss_duty;
    int          miscompares = 0;
    int          check_count = 0;

    always #4 clk_sys = ~clk_sys;

    drc_mode_control uut (.clk_sys(clk_sys), .resetn(resetn), .op_mode(op_mode),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .wake_input_pin(wake_input_pin), .sw_open_cmp(sw_open_cmp),
        .sw_short_cmp(sw_short_cmp), .out_band_cmp(out_band_cmp),
        .load_over_cmp(load_over_cmp), .target_cmp(target_cmp),
        .low_supply_cmp(low_supply_cmp), .below_th1_cmp(below_th1),
        .above_hys1_cmp(above_hys1), .below_th2_cmp(below_th2), .above_hys2_cmp(above_hys2),
        .buck_enable(buck_enable), .buck_pwm(buck_pwm), .full_duty_allow(full_duty_allow),
        .ss_duty(ss_duty), .ss_active(ss_active), .closed_loop(closed_loop),
        .step_up_on(step_up_on), .step_up_pwm(step_up_pwm), .step_up_level(step_up_level),
        .mod_change_evt(mod_change_evt));

    drc_far_side far (.sense_lvl(sense_lvl), .ss_duty(ss_duty), .below_th1(below_th1),
        .above_hys1(above_hys1), .below_th2(below_th2), .above_hys2(above_hys2),
        .target_cmp(target_cmp));

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic ok, input string msg);
        check_count++;
        if (ok !== 1'b1) begin
            miscompares++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask

    task automatic expire(input string msg);
        chk(1'b0, msg);
        tally_and_finish();
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    task automatic set_mode(input drc_mode_t m);
        @(posedge clk_sys);
        op_mode <= m;
        cyc(2);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk_sys);
        reg_wr    <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk_sys);
        reg_rd   <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    // waits until ss_active shows the wanted level, bounded
    task automatic wait_ss(input logic lvl, input int lim);
        int n;
        for (n = 0; n < lim && ss_active !== lvl; n++) cyc(1);
        if (n == lim) expire("soft start level wait ran out");
    endtask

    task automatic t_reset;
        logic [31:0] d;
        rd(ADDR_HARDWARE_CONTROL_REGISTER, d);
        chk(d === {28'h0, HARDWARE_CONTROL_REGISTER_RESET}, "control reset value");
        rd(8'h20, d);
        chk(d === 32'h0, "unmapped read not zero");
        chk(step_up_pwm === 1'b1, "step-up not pwm");
        $display("test reset done");
    endtask

    task automatic t_soft;
        int n;
        set_mode(MODE_RESTART);
        wait_ss(1'b1, 8);
        chk(ss_duty === DUTY_MIN, "first duty");
        for (n = 0; n < 600 && ss_duty !== 8'(DUTY_MIN + DUTY_STEP); n++) cyc(1);
        if (n == 600) expire("first duty step wait ran out");
        for (n = 0; n < 600 && ss_duty === 8'(DUTY_MIN + DUTY_STEP); n++) cyc(1);
        if (n == 600) expire("second duty step wait ran out");
        chk(n == (int'(HOLD_PERIODS_LAST) + 1) * (int'(SW_PERIOD_LAST) + 1), "hold length");
        chk(ss_duty === 8'(DUTY_MIN + 2 * DUTY_STEP), "second step");
        wait_ss(1'b0, 8);
        chk(closed_loop === 1'b1 && buck_pwm === 1'b1, "no closed loop");
        set_mode(MODE_SLEEP);
        cyc(4);
        chk(ss_active === 1'b0 && buck_enable === 1'b0, "sleep left buck on");
        set_mode(MODE_RESTART);
        wait_ss(1'b1, 8);
        chk(ss_duty === DUTY_MIN, "restart duty");
        wait_ss(1'b0, 1600);
        $display("test soft start done");
    endtask

    task automatic t_modes;
        for (int k = 0; k < 5; k++) begin
            set_mode(drc_mode_t'(3'(k)));
            chk(buck_enable === (k < 3), "buck enable by mode");
            if (k == 1) chk(buck_pwm === 1'b0, "stop entry not pfm");
            if (k == 0 || k == 2) chk(buck_pwm === 1'b1, "not pwm");
        end
        set_mode(MODE_NORMAL);
        @(posedge clk_sys);
        low_supply_cmp <= 1'b1;
        cyc(5);
        chk(full_duty_allow === 1'b1, "full duty refused");
        set_mode(MODE_STOP);
        cyc(1);
        chk(full_duty_allow === 1'b0, "full duty in pfm");
        @(posedge clk_sys);
        low_supply_cmp <= 1'b0;
        $display("test modes done");
    endtask

    task automatic t_status;
        logic [31:0] d;
        set_mode(MODE_NORMAL);
        @(posedge clk_sys);
        {sw_open_cmp, sw_short_cmp, out_band_cmp} <= 3'h7;
        cyc(4);
        @(posedge clk_sys);
        {sw_open_cmp, sw_short_cmp, out_band_cmp} <= 3'h0;
        cyc(4);
        chk(buck_enable === 1'b1 && buck_pwm === 1'b1, "status changed mode");
        rd(ADDR_CONV_STAT, d);
        chk(d[2:0] === 3'h7, "status bits");
        rd(ADDR_HARDWARE_CONTROL_REGISTER, d);
        chk(d[3:0] === HARDWARE_CONTROL_REGISTER_RESET, "status changed config");
        wr(ADDR_CONV_STAT, 32'h0000_0007);
        rd(ADDR_CONV_STAT, d);
        chk(d[2:0] === 3'h0, "status not cleared");
        $display("test status done");
    endtask

    task automatic t_auto;
        logic [31:0] d;
        int          ev;
        set_mode(MODE_STOP);
        @(posedge clk_sys);
        load_over_cmp <= 1'b1;
        ev = 0;
        for (int k = 0; k < 10; k++) begin
            cyc(1);
            ev += int'(mod_change_evt === 1'b1);
        end
        chk(buck_pwm === 1'b1 && ev == 1, "auto pwm or event");
        rd(ADDR_WAKE_STAT, d);
        chk(d[0] === 1'b1, "change flag");
        wr(ADDR_WAKE_STAT, 32'h0000_0001);
        @(posedge clk_sys);
        load_over_cmp <= 1'b0;
        cyc(4);
        wr(ADDR_MODE_CTRL, 32'(MODE_STOP));
        cyc(2);
        chk(buck_pwm === 1'b0, "stop command kept pwm");
        wr(ADDR_HARDWARE_CONTROL_REGISTER, 32'h0000_0000);
        @(posedge clk_sys);
        load_over_cmp <= 1'b1;
        cyc(8);
        chk(buck_pwm === 1'b0, "auto change not suppressed");
        @(posedge clk_sys);
        load_over_cmp <= 1'b0;
        wr(ADDR_HARDWARE_CONTROL_REGISTER, 32'h0000_000C);
        @(posedge clk_sys);
        wake_input_pin <= 1'b1;
        cyc(5);
        chk(buck_pwm === 1'b1, "pin high not pwm");
        @(posedge clk_sys);
        wake_input_pin <= 1'b0;
        cyc(5);
        chk(buck_pwm === 1'b0, "pin low not pfm");
        $display("test modulation done");
    endtask

    task automatic t_step_up;
        logic [31:0] d;
        set_mode(MODE_NORMAL);
        wr(ADDR_HARDWARE_CONTROL_REGISTER, 32'h0000_0007);
        @(posedge clk_sys);
        sense_lvl <= 8'h50;
        cyc(5);
        chk(step_up_on === 1'b1 && step_up_level === 1'b1, "level one on");
        wr(ADDR_CONV_STAT, 32'h0000_0008);
        rd(ADDR_CONV_STAT, d);
        chk(d[3] === 1'b1, "flag cleared below threshold");
        @(posedge clk_sys);
        sense_lvl <= 8'h6E;
        cyc(5);
        chk(step_up_on === 1'b1, "off inside hysteresis");
        wr(ADDR_CONV_STAT, 32'h0000_0008);
        rd(ADDR_CONV_STAT, d);
        chk(d[3] === 1'b0, "flag not cleared");
        @(posedge clk_sys);
        sense_lvl <= 8'h80;
        cyc(5);
        chk(step_up_on === 1'b0, "on above hysteresis");
        wr(ADDR_HARDWARE_CONTROL_REGISTER, 32'h0000_0005);
        @(posedge clk_sys);
        sense_lvl <= 8'h50;
        cyc(5);
        chk(step_up_on === 1'b0 && step_up_level === 1'b0, "level two threshold");
        @(posedge clk_sys);
        sense_lvl <= 8'h30;
        set_mode(MODE_STOP);
        cyc(3);
        chk(step_up_on === 1'b1 && step_up_pwm === 1'b1, "step-up in stop");
        set_mode(MODE_SLEEP);
        cyc(2);
        chk(step_up_on === 1'b0, "on in sleep");
        set_mode(MODE_NORMAL);
        wr(ADDR_HARDWARE_CONTROL_REGISTER, 32'h0000_0004);
        cyc(4);
        chk(step_up_on === 1'b0, "on while disabled");
        $display("test step-up done");
    endtask

    initial begin
        resetn  = 1'b0;
        op_mode = MODE_SLEEP;
        {reg_addr, reg_wdata} = '0;
        sense_lvl = 8'h80;
        {reg_wr, reg_rd, wake_input_pin, sw_open_cmp, sw_short_cmp} = '0;
        {out_band_cmp, load_over_cmp, low_supply_cmp} = '0;
        repeat (5) @(posedge clk_sys);
        resetn <= 1'b1;
        t_reset();
        t_soft();
        t_modes();
        t_status();
        t_auto();
        t_step_up();
        tally_and_finish();
    end
endmodule
